// >>> design/dfi_map.vh
// Constants for the subtract-one-from-file instruction block.
// Assumes a 16-bit instruction word and a 12-bit data-memory address.
//
// Contract
// - Opcode 0000 01da; subtract one from operand; update all five flags
// - Destination bit 0: result goes to accumulator, memory untouched
// - Destination bit 1: result written back to the addressed location
// - Region bit 0: operand address resolved inside the access bank
// - Region bit 1: address is bank pointer joined with 8-bit field
// - Region 0, extended set on, field <= 5Fh: indexed literal offset
`ifndef DFI_MAP_VH
`define DFI_MAP_VH

// ----------------------------------------------------------------------
// Instruction fields
// ----------------------------------------------------------------------
`define DFI_OPC_HI        15
`define DFI_OPC_LO        10
`define DFI_OPC_VALUE     6'h01
`define DFI_BIT_DEST      9
`define DFI_BIT_REGION    8
`define DFI_FIELD_HI      7

// ----------------------------------------------------------------------
// Addressing
// ----------------------------------------------------------------------
`define DFI_IDX_LIMIT     8'h5f
`define DFI_ACCESS_SPLIT  8'h80
`define DFI_LOW_BANK      4'h0
`define DFI_SFR_BANK      4'hf

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DFI_RST_ACC       8'h00
`define DFI_RST_ADDR      12'h000
`define DFI_RST_BYTE      8'h00
`define DFI_RST_INSTR     16'h0000

`endif

// >>> design/dfi_alu.v
// Subtract-one arithmetic and flag generation for one operand byte.
// Purely combinational; the core registers everything it uses.
`timescale 1ns/1ps
`default_nettype none

module dfi_alu (
    input  wire [7:0] i_operand,     // Byte read from data memory
    output wire [7:0] o_result,      // Operand minus one
    output wire       o_carry,       // Set when no borrow occurred
    output wire       o_nibble_bf,   // Set when low nibble did not borrow
    output wire       o_negative,    // Result bit 7
    output wire       o_signed_wrap, // Signed overflow
    output wire       o_zero         // Result is zero
);

    // --------------------------------------------------------------
    // Subtraction done as addition of ff so carry means no borrow
    // --------------------------------------------------------------
    wire [8:0] sum_full;
    wire [4:0] sum_low;

    assign sum_full      = {1'b0, i_operand} + 9'h0ff;
    assign sum_low       = {1'b0, i_operand[3:0]} + 5'h0f;
    assign o_result      = sum_full[7:0];
    assign o_carry       = sum_full[8];
    assign o_nibble_bf   = sum_low[4];
    assign o_negative    = sum_full[7];
    // Only 80h wraps from most negative to most positive
    assign o_signed_wrap = i_operand[7] & ~sum_full[7];
    assign o_zero        = (sum_full[7:0] == 8'h00);

endmodule // dfi_alu

`default_nettype wire

// >>> design/dfi_core.v
// Execution core for the subtract-one-from-file instruction.
// Assumes synchronous data memory on the same clock: read data is valid
// while o_mem_rd is high and is sampled at the end of that phase.
// Bank pointer, index base and extended-set enable come from core logic
// on this clock and are read without synchronisers.
`timescale 1ns/1ps
`default_nettype none
`include "dfi_map.vh"

module dfi_core (
    input  wire        i_mclk,              // 50 MHz core clock
    input  wire        i_sys_rst,           // Async reset, active high
    input  wire        i_start,             // Start pulse with instruction
    input  wire [15:0] i_instr,             // Instruction word
    input  wire [3:0]  i_bank_pointer,      // Bank pointer
    input  wire [11:0] i_index_base,        // Index pointer for offsets
    input  wire        i_ext_en,            // Extended instruction set on
    input  wire [7:0]  i_mem_rdata,         // Data memory read data
    output wire [11:0] o_mem_addr,          // Data memory address
    output wire        o_mem_rd,            // Read strobe, one phase
    output wire        o_mem_wr,            // Write strobe, one phase
    output wire [7:0]  o_mem_wdata,         // Write data
    output wire [7:0]  o_acc,               // Accumulator
    output wire        o_carry_flag,        // Carry (no borrow)
    output wire        o_nibble_borrow_flag,// Digit carry
    output wire        o_negative_flag,     // Negative
    output wire        o_signed_wrap_flag,  // Overflow
    output wire        o_zero_flag,         // Zero
    output wire [1:0]  o_phase,             // Current quarter phase
    output wire        o_busy,              // Instruction in progress
    output wire        o_done,              // Pulse in the write phase
    output wire        o_unknown            // Pulse: opcode not matched
);

    // --------------------------------------------------------------
    // States
    // --------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_DEC  = 3'd1;
    localparam [2:0] ST_READ = 3'd2;
    localparam [2:0] ST_PROC = 3'd3;
    localparam [2:0] ST_WR   = 3'd4;

    // --------------------------------------------------------------
    // Operand address resolution
    // --------------------------------------------------------------
    function [11:0] dfi_resolve;
        input [7:0]  field;
        input        region;
        input        ext;
        input [3:0]  bank;
        input [11:0] base;
        begin
            if (region) begin
                dfi_resolve = {bank, field};
            end else if (ext && (field <= `DFI_IDX_LIMIT)) begin
                // Offset wraps inside the 12-bit space
                dfi_resolve = base + {4'h0, field};
            end else if (field < `DFI_ACCESS_SPLIT) begin
                dfi_resolve = {`DFI_LOW_BANK, field};
            end else begin
                dfi_resolve = {`DFI_SFR_BANK, field};
            end
        end
    endfunction

    // --------------------------------------------------------------
    // Registers
    // --------------------------------------------------------------
    reg [2:0]  state_ff;
    reg [2:0]  nxt_state;
    reg [15:0] instr_ff;
    reg [7:0]  operand_ff;
    reg [11:0] addr_ff;
    reg        rd_ff;
    reg        wr_ff;
    reg [7:0]  wdata_ff;
    reg [7:0]  acc_ff;
    reg        c_ff;
    reg        nbf_ff;
    reg        n_ff;
    reg        swf_ff;
    reg        z_ff;
    reg [1:0]  phase_ff;
    reg        busy_ff;
    reg        done_ff;
    reg        unknown_ff;

    wire       opc_match;
    wire [7:0] alu_result;
    wire       alu_c;
    wire       alu_nbf;
    wire       alu_n;
    wire       alu_swf;
    wire       alu_z;

    assign opc_match = (instr_ff[`DFI_OPC_HI:`DFI_OPC_LO] == `DFI_OPC_VALUE);

    dfi_alu u_alu (
        .i_operand     (operand_ff),
        .o_result      (alu_result),
        .o_carry       (alu_c),
        .o_nibble_bf   (alu_nbf),
        .o_negative    (alu_n),
        .o_signed_wrap (alu_swf),
        .o_zero        (alu_z)
    );

    // --------------------------------------------------------------
    // Phase sequencing
    // --------------------------------------------------------------
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (i_start) begin
                    nxt_state = ST_DEC;
                end
            end
            ST_DEC: begin
                // A foreign opcode ends the cycle without any access
                nxt_state = opc_match ? ST_READ : ST_IDLE;
            end
            ST_READ: begin
                nxt_state = ST_PROC;
            end
            ST_PROC: begin
                nxt_state = ST_WR;
            end
            ST_WR: begin
                // Back-to-back start keeps the pipeline without a gap
                nxt_state = i_start ? ST_DEC : ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_ff   <= ST_IDLE;
            instr_ff   <= `DFI_RST_INSTR;
            operand_ff <= `DFI_RST_BYTE;
            addr_ff    <= `DFI_RST_ADDR;
            rd_ff      <= 1'b0;
            wr_ff      <= 1'b0;
            wdata_ff   <= `DFI_RST_BYTE;
            acc_ff     <= `DFI_RST_ACC;
            c_ff       <= 1'b0;
            nbf_ff     <= 1'b0;
            n_ff       <= 1'b0;
            swf_ff     <= 1'b0;
            z_ff       <= 1'b0;
            phase_ff   <= 2'h0;
            busy_ff    <= 1'b0;
            done_ff    <= 1'b0;
            unknown_ff <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            rd_ff      <= 1'b0;
            wr_ff      <= 1'b0;
            done_ff    <= 1'b0;
            unknown_ff <= 1'b0;
            busy_ff    <= (nxt_state != ST_IDLE);
            // Phase output names the quarter the core enters
            phase_ff   <= (nxt_state == ST_IDLE) ? 2'h0 :
                          nxt_state[1:0] - 2'h1;
            if (nxt_state == ST_WR) begin
                phase_ff <= 2'h3;
            end
            case (state_ff)
                ST_IDLE: begin
                    if (i_start) begin
                        instr_ff <= i_instr;
                    end
                end
                ST_DEC: begin
                    if (opc_match) begin
                        addr_ff <= dfi_resolve(
                            instr_ff[`DFI_FIELD_HI:0],
                            instr_ff[`DFI_BIT_REGION],
                            i_ext_en, i_bank_pointer, i_index_base);
                        rd_ff   <= 1'b1;
                    end else begin
                        unknown_ff <= 1'b1;
                    end
                end
                ST_READ: begin
                    operand_ff <= i_mem_rdata;
                end
                ST_PROC: begin
                    c_ff    <= alu_c;
                    nbf_ff  <= alu_nbf;
                    n_ff    <= alu_n;
                    swf_ff  <= alu_swf;
                    z_ff    <= alu_z;
                    done_ff <= 1'b1;
                    if (instr_ff[`DFI_BIT_DEST]) begin
                        wr_ff    <= 1'b1;
                        wdata_ff <= alu_result;
                    end else begin
                        acc_ff   <= alu_result;
                    end
                end
                ST_WR: begin
                    if (i_start) begin
                        instr_ff <= i_instr;
                    end
                end
                default: begin
                    instr_ff <= instr_ff;
                end
            endcase
        end
    end

    // --------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------
    assign o_mem_addr           = addr_ff;
    assign o_mem_rd             = rd_ff;
    assign o_mem_wr             = wr_ff;
    assign o_mem_wdata          = wdata_ff;
    assign o_acc                = acc_ff;
    assign o_carry_flag         = c_ff;
    assign o_nibble_borrow_flag = nbf_ff;
    assign o_negative_flag      = n_ff;
    assign o_signed_wrap_flag   = swf_ff;
    assign o_zero_flag          = z_ff;
    assign o_phase              = phase_ff;
    assign o_busy               = busy_ff;
    assign o_done               = done_ff;
    assign o_unknown            = unknown_ff;

endmodule // dfi_core

`default_nettype wire

// >>> sim/dfi_core_assertions.sv
// Protocol checker for the subtract-one-from-file core.
// Assumes the four-phase timing of the core's hand-over contract.
`timescale 1ns/1ps
`default_nettype none

module dfi_core_assertions (
    input wire logic        i_mclk,               // Clock
    input wire logic        i_sys_rst,            // Reset
    input wire logic        i_start,              // Start
    input wire logic [15:0] i_instr,              // Word
    input wire logic [3:0]  i_bank_pointer,       // Bank
    input wire logic [11:0] i_index_base,         // Index base
    input wire logic        i_ext_en,             // Extended set
    input wire logic [7:0]  i_mem_rdata,          // Read data
    input wire logic [11:0] o_mem_addr,           // Address
    input wire logic        o_mem_rd,             // Read
    input wire logic        o_mem_wr,             // Write
    input wire logic [7:0]  o_mem_wdata,          // Write data
    input wire logic [7:0]  o_acc,                // Accumulator
    input wire logic        o_carry_flag,         // C
    input wire logic        o_nibble_borrow_flag, // Nibble borrow
    input wire logic        o_negative_flag,      // N
    input wire logic        o_signed_wrap_flag,   // Signed wrap
    input wire logic        o_zero_flag,          // Z
    input wire logic [1:0]  o_phase,              // Phase
    input wire logic        o_busy,               // Busy
    input wire logic        o_done,               // Done
    input wire logic        o_unknown             // No match
);
    // --------------------------------
    // Shadow of the word and operand
    // --------------------------------
    logic [15:0] held_ff;
    logic [7:0]  opd_ff;
    wire         take_w = i_start && (!o_busy || o_done);
    wire  [7:0]  res_w  = opd_ff - 8'h01;
    wire         idx_w  = i_ext_en && (held_ff[7:0] <= 8'h5f);

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            held_ff <= 16'h0000;
            opd_ff  <= 8'h00;
        end else begin
            if (take_w)
                held_ff <= i_instr;
            if (o_mem_rd)
                opd_ff <= i_mem_rdata;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);

    sequence s_run;
        (o_busy && o_phase == 2'd0) ##1 (o_mem_rd && o_phase == 2'd1)
        ##1 (!o_mem_rd && o_phase == 2'd2) ##1 (o_done && o_phase == 2'd3);
    endsequence

    // --------------------------------
    // Properties
    // --------------------------------
    phase_order_a: assert property (
        take_w && i_instr[15:10] == 6'h01 |=> s_run) else $error("order");
    opcode_miss_a: assert property (
        take_w && i_instr[15:10] != 6'h01 |-> ##2 (o_unknown && !o_mem_rd))
        else $error("miss");
    dest_write_a: assert property (
        o_done |-> o_mem_wr == held_ff[9]) else $error("dest");
    write_data_a: assert property (
        $rose(o_mem_wr) |-> o_mem_wdata == res_w) else $error("wdata");
    acc_dest_a: assert property (
        o_done |-> o_acc == (held_ff[9] ? $past(o_acc) : res_w))
        else $error("acc");
    flag_update_a: assert property (
        o_done |-> o_carry_flag == (opd_ff != 8'h00)
        && o_nibble_borrow_flag == (opd_ff[3:0] != 4'h0)
        && o_negative_flag == res_w[7] && o_zero_flag == (res_w == 8'h00)
        && o_signed_wrap_flag == (opd_ff == 8'h80)) else $error("flags");
    bank_addr_a: assert property (
        o_mem_rd && held_ff[8] |-> o_mem_addr == {i_bank_pointer,
        held_ff[7:0]}) else $error("bank");
    access_addr_a: assert property (
        o_mem_rd && !held_ff[8] && !idx_w |-> o_mem_addr ==
        {{4{held_ff[7]}}, held_ff[7:0]}) else $error("access");
    index_addr_a: assert property (
        o_mem_rd && !held_ff[8] && idx_w |-> o_mem_addr ==
        i_index_base + {4'h0, held_ff[7:0]}) else $error("index");
endmodule // dfi_core_assertions

bind dfi_core dfi_core_assertions u_chk (.i_mclk, .i_sys_rst, .i_start,
    .i_instr, .i_bank_pointer, .i_index_base, .i_ext_en, .i_mem_rdata,
    .o_mem_addr, .o_mem_rd, .o_mem_wr, .o_mem_wdata, .o_acc, .o_carry_flag,
    .o_nibble_borrow_flag, .o_negative_flag, .o_signed_wrap_flag,
    .o_zero_flag, .o_phase, .o_busy, .o_done, .o_unknown);
`default_nettype wire

// >>> sim/decrement_file_instruction_tb_top.sv
// Self-checking bench for the subtract-one-from-file core.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
`default_nettype none

module decrement_file_instruction_tb_top;
    logic        i_mclk, i_sys_rst, i_start, i_ext_en, queued;
    logic [15:0] i_instr;
    logic [3:0]  i_bank_pointer;
    logic [11:0] i_index_base, o_mem_addr;
    logic [7:0]  i_mem_rdata, o_mem_wdata, o_acc, acc_m;
    logic [4:0]  flg_m;
    logic        o_mem_rd, o_mem_wr, o_carry_flag, o_nibble_borrow_flag;
    logic        o_negative_flag, o_signed_wrap_flag, o_zero_flag;
    logic [1:0]  o_phase;
    logic        o_busy, o_done, o_unknown;
    integer      failures, check_count;

    dfi_core dut (.i_mclk, .i_sys_rst, .i_start, .i_instr, .i_bank_pointer,
        .i_index_base, .i_ext_en, .i_mem_rdata, .o_mem_addr, .o_mem_rd,
        .o_mem_wr, .o_mem_wdata, .o_acc, .o_carry_flag, .o_nibble_borrow_flag,
        .o_negative_flag, .o_signed_wrap_flag, .o_zero_flag, .o_phase,
        .o_busy, .o_done, .o_unknown);

    always #10 i_mclk = ~i_mclk;

    task automatic chk(input [15:0] got, input [15:0] exp);
        check_count = check_count + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // --------------------------------
    // One instruction; nx queues the next in the write phase
    // --------------------------------
    task automatic exec(input [15:0] ins, input [7:0] v, input [11:0] ea,
                        input [15:0] nx);
        logic [7:0] r;
        integer     n;
        r = v - 8'h01;
        n = 0;
        if (!queued) begin
            @(posedge i_mclk);
            i_start <= 1'b1;
            i_instr <= ins;
            @(posedge i_mclk);
        end
        queued = 1'b0;
        i_start <= 1'b0;
        i_mem_rdata <= v;
        do begin
            @(posedge i_mclk);
            n = n + 1;
            if (o_mem_rd === 1'b1) begin
                chk(o_mem_addr, ea);
                // Stale data after the read phase must not be used
                i_mem_rdata <= ~v;
            end
            if (o_phase === 2'd2 && nx != 16'h0000) begin
                i_start <= 1'b1;
                i_instr <= nx;
                queued = 1'b1;
            end
        end while (o_done !== 1'b1 && n < 8);
        chk(n, 4);
        chk(o_mem_wr, ins[9]);
        if (!ins[9])
            acc_m = r;
        chk(o_acc, acc_m);
        if (ins[9])
            chk(o_mem_wdata, r);
        flg_m = {v != 8'h00, v[3:0] != 4'h0, r[7], v == 8'h80, r == 8'h00};
        chk({o_carry_flag, o_nibble_borrow_flag, o_negative_flag,
            o_signed_wrap_flag, o_zero_flag}, flg_m);
    endtask

    task automatic t_bank;
        i_bank_pointer <= 4'h3;
        exec(16'h0722, 8'h01, 12'h322, 16'h0000);
    endtask

    task automatic t_access;
        i_ext_en <= 1'b0;
        exec(16'h0490, 8'h00, 12'hf90, 16'h0000);
        exec(16'h0430, 8'h80, 12'h030, 16'h0000);
    endtask

    task automatic t_index;
        i_ext_en <= 1'b1;
        i_index_base <= 12'hff0;
        exec(16'h065f, 8'h80, 12'h04f, 16'h0000);
        exec(16'h0460, 8'h10, 12'h060, 16'h0000);
        exec(16'h0705, 8'h3c, 12'h305, 16'h0000);
    endtask

    task automatic t_b2b;
        i_ext_en <= 1'b0;
        exec(16'h0411, 8'h55, 12'h011, 16'h0712);
        exec(16'h0712, 8'h00, 12'h312, 16'h0000);
    endtask

    task automatic t_unknown;
        @(posedge i_mclk);
        i_start <= 1'b1;
        i_instr <= 16'h0822;
        @(posedge i_mclk);
        i_start <= 1'b0;
        repeat (2) @(posedge i_mclk);
        chk({o_unknown, o_mem_rd}, 2'b10);
        repeat (3) @(posedge i_mclk);
        chk({o_busy, o_acc}, {1'b0, acc_m});
        // A foreign opcode must leave every flag as it was
        chk({o_carry_flag, o_nibble_borrow_flag, o_negative_flag,
            o_signed_wrap_flag, o_zero_flag}, flg_m);
    endtask

    task results;
        if (failures == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        i_mclk = 1'b0;
        i_sys_rst = 1'b1;
        i_start = 1'b0;
        i_ext_en = 1'b0;
        queued = 1'b0;
        i_instr = 16'h0000;
        i_bank_pointer = 4'h0;
        i_index_base = 12'h000;
        i_mem_rdata = 8'h00;
        acc_m = 8'h00;
        flg_m = 5'h00;
        failures = 0;
        check_count = 0;
        repeat (20) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        @(posedge i_mclk);
        chk({o_busy, o_acc}, 16'h0000);
        t_bank;
        t_access;
        t_index;
        t_b2b;
        t_unknown;
        results;
    end

    // Whole run needs about 80 cycles; 1000 means a hang
    initial begin
        #20000;
        failures = failures + 1;
        results;
    end
endmodule // decrement_file_instruction_tb_top
`default_nettype wire
